// >>> common/gdm_mux_if.sv
// signals between the register block and the pin 0 function mux
interface gdm_mux_if;
  import gdm_pkg::*;

  logic [SEL_W-1:0] sel;
  logic             user_value;
  logic             mute_left;
  logic             mute_right;
  logic             clock_invalid;
  logic             warning_n;
  logic             fault_n;
  logic             serial_data;
  logic             spi_mosi;
  logic             mux_out;

  // register block side
  modport src (
    output sel, user_value, mute_left, mute_right, clock_invalid,
           warning_n, fault_n, serial_data, spi_mosi,
    input  mux_out
  );

  // mux side
  modport mux (
    input  sel, user_value, mute_left, mute_right, clock_invalid,
           warning_n, fault_n, serial_data, spi_mosi,
    output mux_out
  );

endinterface

// >>> common/gdm_pkg.sv
// constants shared by the pin direction and function mux block
package gdm_pkg;

  // ****************************************************************
  // widths and counts
  // ****************************************************************
  localparam int unsigned NUM_PINS   = 3;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned SEL_W      = 4;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] PIN_DIRECTION_CONTROL_OFF = 8'h60;
  localparam logic [ADDR_W-1:0] PIN0_FUNCTION_SELECT_OFF  = 8'h61;
  localparam logic [ADDR_W-1:0] PIN_USER_VALUE_OFF        = 8'h65;
  localparam logic [ADDR_W-1:0] PIN_LEVEL_STATUS_OFF      = 8'h66;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0] PIN_DIRECTION_CONTROL_RST = 8'h00;
  localparam logic [DATA_W-1:0] PIN0_FUNCTION_SELECT_RST  = 8'h00;
  localparam logic [DATA_W-1:0] PIN_USER_VALUE_RST        = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE_VALUE           = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned SEL_LSB        = 0;
  localparam int unsigned USER_VALUE_LSB = 0;

  // ****************************************************************
  // pin 0 function selector codes
  // ****************************************************************
  localparam logic [SEL_W-1:0] FUNC_OFF_LOW     = 4'h0;
  localparam logic [SEL_W-1:0] FUNC_USER_VALUE  = 4'h2;
  localparam logic [SEL_W-1:0] FUNC_MUTE_BOTH   = 4'h3;
  localparam logic [SEL_W-1:0] FUNC_MUTE_LEFT   = 4'h4;
  localparam logic [SEL_W-1:0] FUNC_MUTE_RIGHT  = 4'h5;
  localparam logic [SEL_W-1:0] FUNC_CLK_INVALID = 4'h6;
  localparam logic [SEL_W-1:0] FUNC_WARNING     = 4'h8;
  localparam logic [SEL_W-1:0] FUNC_SERIAL_DATA = 4'h9;
  localparam logic [SEL_W-1:0] FUNC_FAULT       = 4'hb;
  localparam logic [SEL_W-1:0] FUNC_SPI_MOSI    = 4'hc;

endpackage

// >>> rtl/gdm_pin0_mux.sv
// pin 0 function selector, purely combinational
module gdm_pin0_mux (
  // selector and sources
  gdm_mux_if.mux m
);
  import gdm_pkg::*;

  // ****************************************************************
  // function decode
  // ****************************************************************

  // pick one source from the 4-bit code
  always_comb begin
    case (m.sel)
      FUNC_OFF_LOW:     m.mux_out = 1'b0;                       // see (RQ4)
      FUNC_USER_VALUE:  m.mux_out = m.user_value;               // see (RQ4)
      FUNC_MUTE_BOTH:   m.mux_out = m.mute_left & m.mute_right; // see (RQ5)
      FUNC_MUTE_LEFT:   m.mux_out = m.mute_left;                // see (RQ6)
      FUNC_MUTE_RIGHT:  m.mux_out = m.mute_right;               // see (RQ6)
      FUNC_CLK_INVALID: m.mux_out = m.clock_invalid;            // see (RQ7)
      FUNC_WARNING:     m.mux_out = m.warning_n;                // see (RQ8)
      FUNC_SERIAL_DATA: m.mux_out = m.serial_data;              // see (RQ9)
      FUNC_FAULT:       m.mux_out = m.fault_n;                  // see (RQ10)
      FUNC_SPI_MOSI:    m.mux_out = m.spi_mosi;                 // see (RQ11)
      default:          m.mux_out = 1'b0;                       // see (RQ12)
    endcase
  end

endmodule

// >>> rtl/gdm_top.sv
// register file, direction control and pin drivers for three general pins
//
// What this block does
// (RQ1) Each of the three pins has its own direction bit, bit n for pin n, where 0 means input and 1 means output.
// (RQ2) The direction register sits at 60h and resets to 00h so every pin starts as an input.
// (RQ3) The pin 0 selector is bits 3-0 of the register at 61h, reset 00h, with the upper four bits kept as read/write.
// (RQ4) Code 0000 drives pin 0 low and code 0010 drives it with the user value held in the register at 65h.
// (RQ5) Code 0011 drives pin 0 with a flag that is high only while both channels are auto-muted.
// (RQ6) Code 0100 drives pin 0 with the left auto-mute flag and code 0101 with the right one.
// (RQ7) Code 0110 drives pin 0 with the clock-invalid flag for a clock error or missing clock.
// (RQ8) Code 1000 drives pin 0 with the active-low warning output.
// (RQ9) Code 1001 routes the serial audio data output onto pin 0.
// (RQ10) Code 1011 drives pin 0 with the active-low fault output.
// (RQ11) Code 1100 makes pin 0 carry the SPI master data-out line used for coefficient loading.
// (RQ12) Any other code drives pin 0 low, and a function reaches the pin only while the pin is set as an output.
module gdm_top #(
  parameter int unsigned PINS = gdm_pkg::NUM_PINS
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       nrst,

  // register access port
  input  wire logic [gdm_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                       reg_wr_en,
  input  wire logic [gdm_pkg::DATA_W-1:0] reg_wr_data,
  input  wire logic                       reg_rd_en,
  output logic      [gdm_pkg::DATA_W-1:0] reg_rd_data,
  output logic                            reg_rd_valid,

  // internal status sources for pin 0
  input  wire logic                       mute_left,
  input  wire logic                       mute_right,
  input  wire logic                       clock_invalid,
  input  wire logic                       warning_out_n,
  input  wire logic                       fault_out_n,
  input  wire logic                       serial_audio_data_out,
  input  wire logic                       spi_mosi,

  // general pins, three signals each
  input  wire logic [PINS-1:0]            general_pin_in,
  output logic      [PINS-1:0]            general_pin_out,
  output logic      [PINS-1:0]            general_pin_oe,

  // direction bits as seen by the rest of the device
  output logic                            pin0_output_enable,
  output logic                            pin1_output_enable,
  output logic                            pin2_output_enable
);
  import gdm_pkg::*;

  // ****************************************************************
  // register map
  // ****************************************************************
  // 60h  direction bits, bit n sets pin n as output
  // 61h  pin 0 function code in bits 3-0
  // 65h  user drive values, bit n for pin n
  // 66h  sampled pin levels, read only
  // any other offset reads as zero and ignores writes
  // all stored bits read back, reserved ones included

  // ****************************************************************
  // helpers
  // ****************************************************************

  // true when an access targets the given offset
  function automatic logic addr_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offset
  );
    addr_hit = (addr == offset);
  endfunction

  // widen the sampled pin levels to a register byte, upper bits zero
  function automatic logic [DATA_W-1:0] level_byte(
    input logic [PINS-1:0] levels
  );
    level_byte = {{(DATA_W-PINS){1'b0}}, levels};
  endfunction

  // drive value of one pin, held low while the pin is an input
  function automatic logic gated_drive(
    input logic dir_bit,
    input logic value
  );
    gated_drive = dir_bit & value;
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************

  // software-visible registers
  logic [DATA_W-1:0] dir_ctrl_reg;
  logic [DATA_W-1:0] dir_ctrl_next;
  logic [DATA_W-1:0] func_sel_reg;
  logic [DATA_W-1:0] func_sel_next;
  logic [DATA_W-1:0] user_value_reg;
  logic [DATA_W-1:0] user_value_next;

  // sampled pin levels for readback
  logic [PINS-1:0]   pin_level_reg;
  logic [PINS-1:0]   pin_level_next;

  // read answer
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] rd_data_next;
  logic              rd_valid_reg;
  logic              rd_valid_next;

  // pin drivers
  logic [PINS-1:0]   pin_out_reg;
  logic [PINS-1:0]   pin_out_next;
  logic [PINS-1:0]   pin_oe_reg;
  logic [PINS-1:0]   pin_oe_next;

  // value each pin would drive as an output
  logic [PINS-1:0]   pin_func_value;

  // write decode
  logic              wr_dir;
  logic              wr_sel;
  logic              wr_user;

  // link to the function mux
  gdm_mux_if mux_link ();

  // ****************************************************************
  // write decode
  // ****************************************************************

  // one strobe per writable register
  always_comb begin
    wr_dir  = 1'b0;
    wr_sel  = 1'b0;
    wr_user = 1'b0;
    if (reg_wr_en && addr_hit(reg_addr, PIN_DIRECTION_CONTROL_OFF)) begin
      wr_dir = 1'b1;  // see (RQ2)
    end else if (reg_wr_en && addr_hit(reg_addr, PIN0_FUNCTION_SELECT_OFF)) begin
      wr_sel = 1'b1;  // see (RQ3)
    end else if (reg_wr_en && addr_hit(reg_addr, PIN_USER_VALUE_OFF)) begin
      wr_user = 1'b1; // see (RQ4)
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************

  // next values: full byte stored, reserved bits kept read/write
  always_comb begin
    dir_ctrl_next   = dir_ctrl_reg;
    func_sel_next   = func_sel_reg;
    user_value_next = user_value_reg;
    if (wr_dir) begin
      dir_ctrl_next = reg_wr_data;   // see (RQ1)
    end
    if (wr_sel) begin
      func_sel_next = reg_wr_data;   // see (RQ3)
    end
    if (wr_user) begin
      user_value_next = reg_wr_data; // see (RQ4)
    end
  end

  // register the configuration
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dir_ctrl_reg   <= PIN_DIRECTION_CONTROL_RST; // see (RQ2)
      func_sel_reg   <= PIN0_FUNCTION_SELECT_RST;  // see (RQ3)
      user_value_reg <= PIN_USER_VALUE_RST;
    end else begin
      dir_ctrl_reg   <= dir_ctrl_next;
      func_sel_reg   <= func_sel_next;
      user_value_reg <= user_value_next;
    end
  end

  // ****************************************************************
  // pin level sampling
  // ****************************************************************

  // pins are synchronous to clk, sampled every cycle
  always_comb begin
    pin_level_next = general_pin_in;
  end

  // register the sampled levels
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_level_reg <= '0;
    end else begin
      pin_level_reg <= pin_level_next;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************

  // answer the addressed register, unmapped reads give zero
  // a write in the same cycle shows only on the next read
  always_comb begin
    rd_data_next  = rd_data_reg;
    rd_valid_next = reg_rd_en;
    if (reg_rd_en) begin
      if (addr_hit(reg_addr, PIN_DIRECTION_CONTROL_OFF)) begin
        rd_data_next = dir_ctrl_reg;
      end else if (addr_hit(reg_addr, PIN0_FUNCTION_SELECT_OFF)) begin
        rd_data_next = func_sel_reg;
      end else if (addr_hit(reg_addr, PIN_USER_VALUE_OFF)) begin
        rd_data_next = user_value_reg;
      end else if (addr_hit(reg_addr, PIN_LEVEL_STATUS_OFF)) begin
        rd_data_next = level_byte(pin_level_reg);
      end else begin
        rd_data_next = READ_IDLE_VALUE;
      end
    end
  end

  // register the answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_reg  <= READ_IDLE_VALUE;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // ****************************************************************
  // pin 0 function mux
  // ****************************************************************

  // feed the selector and sources
  assign mux_link.sel           = func_sel_reg[SEL_LSB +: SEL_W];  // see (RQ3)
  assign mux_link.user_value    = user_value_reg[USER_VALUE_LSB];  // see (RQ4)
  assign mux_link.mute_left     = mute_left;
  assign mux_link.mute_right    = mute_right;
  assign mux_link.clock_invalid = clock_invalid;
  assign mux_link.warning_n     = warning_out_n;
  assign mux_link.fault_n       = fault_out_n;
  assign mux_link.serial_data   = serial_audio_data_out;
  assign mux_link.spi_mosi      = spi_mosi;

  // combinational code decode
  gdm_pin0_mux u_pin0_mux (
    .m (mux_link.mux)
  );

  // ****************************************************************
  // pin function values
  // ****************************************************************

  // pin 0 from the mux, other pins from their user value bits
  always_comb begin
    pin_func_value    = user_value_reg[USER_VALUE_LSB +: PINS];
    pin_func_value[0] = mux_link.mux_out;
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************

  // one direction bit and one driver per pin
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      // drive only while set as output, hold low otherwise
      always_comb begin
        pin_oe_next[gi]  = dir_ctrl_reg[gi];                        // see (RQ1)
        pin_out_next[gi] = gated_drive(dir_ctrl_reg[gi], pin_func_value[gi]); // see (RQ12)
      end

      // register the driver state
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          pin_oe_reg[gi]  <= 1'b0; // see (RQ2)
          pin_out_reg[gi] <= 1'b0;
        end else begin
          pin_oe_reg[gi]  <= pin_oe_next[gi];
          pin_out_reg[gi] <= pin_out_next[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // outputs
  // ****************************************************************

  // register bus answer, straight from flip-flops
  assign reg_rd_data        = rd_data_reg;
  assign reg_rd_valid       = rd_valid_reg;

  // pin drivers and direction copies, straight from flip-flops
  assign general_pin_out    = pin_out_reg;
  assign general_pin_oe     = pin_oe_reg;
  assign pin0_output_enable = pin_oe_reg[0];
  assign pin1_output_enable = pin_oe_reg[1];
  assign pin2_output_enable = pin_oe_reg[2];

endmodule

// >>> verification/gdm_board_model.sv
// board logic sharing the three general pins with the device
module gdm_board_model (
  // device side of the pins
  input  wire logic [2:0] pin_oe,
  input  wire logic [2:0] pin_out,
  // level the board puts on pins it owns
  input  wire logic [2:0] ext_drive,
  // resolved pin levels
  output logic      [2:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // device wins where it drives, board elsewhere
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_drive);
endmodule

// >>> verification/gdm_top_props.sv
// checker with the concurrent properties of the pin direction and function mux
module gdm_top_props #(
  parameter int unsigned PINS = gdm_pkg::NUM_PINS
) (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       nrst,
  // register access port
  input wire logic [gdm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic                       reg_wr_en,
  input wire logic [gdm_pkg::DATA_W-1:0] reg_wr_data,
  input wire logic                       reg_rd_en,
  input wire logic [gdm_pkg::DATA_W-1:0] reg_rd_data,
  input wire logic                       reg_rd_valid,
  // status sources
  input wire logic                       mute_left,
  input wire logic                       mute_right,
  input wire logic                       clock_invalid,
  input wire logic                       warning_out_n,
  input wire logic                       fault_out_n,
  input wire logic                       serial_audio_data_out,
  input wire logic                       spi_mosi,
  // pins and enables
  input wire logic [PINS-1:0]            general_pin_in,
  input wire logic [PINS-1:0]            general_pin_out,
  input wire logic [PINS-1:0]            general_pin_oe,
  input wire logic                       pin0_output_enable,
  input wire logic                       pin1_output_enable,
  input wire logic                       pin2_output_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  import gdm_pkg::*;

  logic [DATA_W-1:0] dir_q;
  logic [DATA_W-1:0] sel_q;
  logic [DATA_W-1:0] usr_q;
  logic              src0;

  // ****************************************************************
  // mirror of the writable registers
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dir_q <= 8'h00;
      sel_q <= 8'h00;
      usr_q <= 8'h00;
    end else if (reg_wr_en) begin
      if (reg_addr == 8'h60) dir_q <= reg_wr_data;
      if (reg_addr == 8'h61) sel_q <= reg_wr_data;
      if (reg_addr == 8'h65) usr_q <= reg_wr_data;
    end
  end

  // source chosen by the pin 0 selector
  always_comb begin
    case (sel_q[3:0])
      4'h2:    src0 = usr_q[0];
      4'h3:    src0 = mute_left & mute_right;
      4'h4:    src0 = mute_left;
      4'h5:    src0 = mute_right;
      4'h6:    src0 = clock_invalid;
      4'h8:    src0 = warning_out_n;
      4'h9:    src0 = serial_audio_data_out;
      4'hb:    src0 = fault_out_n;
      4'hc:    src0 = spi_mosi;
      default: src0 = 1'b0;
    endcase
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ****************************************************************
  // properties
  // ****************************************************************
  AST_RST_DIR: assert property ($rose(nrst) |-> general_pin_oe == '0 && !reg_rd_valid)
    else $error("pins not inputs after reset");
  AST_OE_FOLLOWS_DIR: assert property (general_pin_oe == $past(dir_q[2:0]))
    else $error("pin enables differ from direction register");
  AST_ENABLE_COPY: assert property ({pin2_output_enable, pin1_output_enable, pin0_output_enable} == general_pin_oe)
    else $error("enable copies differ from pin enables");
  AST_OUT_GATED: assert property ((general_pin_out & ~general_pin_oe) == '0)
    else $error("input pin has drive value");
  AST_PIN0_FUNC: assert property (general_pin_out[0] == $past(dir_q[0] & src0))
    else $error("pin 0 carries wrong function");
  AST_PIN0_RESERVED: assert property ($past(sel_q[3:0]) inside {4'h1, 4'h7, 4'ha, 4'hd, 4'he, 4'hf}
    |-> !general_pin_out[0])
    else $error("reserved code drives pin 0 high");
  AST_RD_PULSE: assert property (reg_rd_en |=> reg_rd_valid ##1 (reg_rd_valid == $past(reg_rd_en)))
    else $error("read valid timing wrong");
  AST_RD_HOLD: assert property (!reg_rd_valid |-> $stable(reg_rd_data))
    else $error("read data changed without valid");
  AST_RD_SEL: assert property (reg_rd_en && reg_addr == 8'h61 |=> reg_rd_data == $past(sel_q))
    else $error("selector register read wrong");

  COV_DIR_WRITE: cover property (reg_wr_en && reg_addr == 8'h60);
  COV_READ: cover property (reg_rd_valid);
  COV_PIN0_HIGH: cover property (general_pin_oe[0] && general_pin_out[0]);
endmodule

bind gdm_top gdm_top_props #(.PINS(PINS)) u_gdm_top_props (
  .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
  .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
  .mute_left(mute_left), .mute_right(mute_right), .clock_invalid(clock_invalid),
  .warning_out_n(warning_out_n), .fault_out_n(fault_out_n), .serial_audio_data_out(serial_audio_data_out),
  .spi_mosi(spi_mosi), .general_pin_in(general_pin_in), .general_pin_out(general_pin_out),
  .general_pin_oe(general_pin_oe), .pin0_output_enable(pin0_output_enable),
  .pin1_output_enable(pin1_output_enable), .pin2_output_enable(pin2_output_enable)
);

// >>> verification/gpio_direction_function_mux_test.sv
// self-checking bench for the pin direction and function mux
module gpio_direction_function_mux_test;
  timeunit 1ns;
  timeprecision 1ps;
  import gdm_pkg::*;

  logic       clk, nrst, reg_wr_en, reg_rd_en, reg_rd_valid;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
  logic [6:0] srcs;
  logic [2:0] pin_in, pin_out, pin_oe, ext_drive;
  logic [7:0] rd_q[$];
  int         n_mismatch = 0;
  int         comparisons = 0;

  gdm_top u_gdm_top (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .mute_left(srcs[0]), .mute_right(srcs[1]), .clock_invalid(srcs[2]), .warning_out_n(srcs[3]),
    .fault_out_n(srcs[4]), .serial_audio_data_out(srcs[5]), .spi_mosi(srcs[6]),
    .general_pin_in(pin_in), .general_pin_out(pin_out), .general_pin_oe(pin_oe),
    .pin0_output_enable(), .pin1_output_enable(), .pin2_output_enable()
  );
  gdm_board_model u_gdm_board_model (.pin_oe(pin_oe), .pin_out(pin_out), .ext_drive(ext_drive), .pin_level(pin_in));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic test_done;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch read data expected %h seen %h", e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wr_data = d;
    @(posedge clk);
    #1;
    reg_wr_en = 1'b0;
  endtask

  // notes the expected byte, then issues the read
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    @(posedge clk);
    #1;
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd_en = 1'b0;
  endtask

  // expected pin 0 level for a selector code
  function automatic logic f0(input logic [3:0] c, input logic [6:0] s, input logic u);
    case (c)
      4'h2: return u;
      4'h3: return s[0] & s[1];
      4'h4: return s[0];
      4'h5: return s[1];
      4'h6: return s[2];
      4'h8: return s[3];
      4'h9: return s[5];
      4'hb: return s[4];
      4'hc: return s[6];
      default: return 1'b0;
    endcase
  endfunction

  // read answers taken off the queue mid-cycle
  always @(negedge clk) begin
    if (reg_rd_valid === 1'b1) begin
      if (rd_q.size() == 0) begin
        n_mismatch++;
        $display("mismatch read valid expected none seen %h", reg_rd_data);
      end else begin
        chk_byte(rd_q.pop_front(), reg_rd_data);
      end
    end
  end

  // watchdog
  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [7:0] d, u;
    logic [3:0] c;
    logic [2:0] e;
    nrst = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
    srcs = 7'h00;
    ext_drive = 3'h0;
    d = 8'($urandom(22));
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
    rd(8'h60, 8'h00);
    rd(8'h61, 8'h00);
    rd(8'h65, 8'h00);
    rd(8'h70, 8'h00);
    // every code four times, random direction and sources
    for (int i = 0; i < 64; i++) begin
      c = i[3:0];
      d = 8'($urandom);
      u = 8'($urandom);
      wr(8'h61, {d[7:4], c});
      wr(8'h65, u);
      @(posedge clk);
      #1;
      srcs = 7'($urandom);
      ext_drive = 3'($urandom);
      wr(8'h60, d);
      repeat (3) @(posedge clk);
      e = (d[2:0] & {u[2:1], f0(c, srcs, u[0])}) | (~d[2:0] & ext_drive);
      rd(8'h66, {5'h00, e});
      rd(8'h61, {d[7:4], c});
      rd(8'h60, d);
    end
    repeat (3) @(posedge clk);
    // every noted read must have been answered
    if (rd_q.size() != 0) begin
      n_mismatch++;
      $display("mismatch pending reads expected %0d seen %0d", 0, rd_q.size());
    end
    test_done();
  end
endmodule
